/* File: triple_comparator_defs.vh */
// Register map, field positions, reset values and codes of the triple comparator block
`ifndef TRIPLE_COMPARATOR_DEFS_VH
`define TRIPLE_COMPARATOR_DEFS_VH

// Byte offsets on the register port
`define CMP_CTRL0_OFS 8'h00
`define CMP_CTRL1_OFS 8'h04
`define CMP_CTRL2_OFS 8'h08
`define CMP_CTRL_STRIDE 4
`define CMP_STATUS_OFS 8'h0c
`define CMP_INT_STATUS_OFS 8'h10
`define CMP_INT_MASK_OFS 8'h14

// Field positions of comparator_control
`define CMP_ON_BIT 15
`define CMP_OE_BIT 14
`define CMP_INV_BIT 13
`define CMP_FLAG_BIT 9
`define CMP_RESULT_BIT 8
`define CMP_EDGE_HI 7
`define CMP_EDGE_LO 6
`define CMP_PLUS_BIT 4
`define CMP_MINUS_HI 1
`define CMP_MINUS_LO 0

// Field positions of comparator_status
`define CMP_STAT_FLAG_LSB 8
`define CMP_STAT_RESULT_LSB 0

// Reset values
`define CMP_CTRL_RESET 16'h0000
`define CMP_INT_MASK_RESET 3'h0

// Event edge select codes
`define CMP_EDGE_NONE 2'h0
`define CMP_EDGE_RISE 2'h1
`define CMP_EDGE_FALL 2'h2
`define CMP_EDGE_ANY 2'h3

// Inverting input select codes
`define CMP_MINUS_B 2'h0
`define CMP_MINUS_C 2'h1
`define CMP_MINUS_D 2'h2
`define CMP_MINUS_REF 2'h3

`endif

/* File: comparator_channel.v */
// One comparator: input selection, compare, polarity and pin drive
`include "triple_comparator_defs.vh"

module comparator_channel #(
  parameter AW = 10
) (
  input wire [AW-1:0] analogInputA,
  input wire [AW-1:0] analogInputB,
  input wire [AW-1:0] analogInputC,
  input wire [AW-1:0] analogInputD,
  input wire [AW-1:0] referencePlus,
  input wire [AW-1:0] referenceMinus,
  input wire comparatorOn,
  input wire plusInputSelect,
  input wire [1:0] minusInputSelect,
  input wire outputInvert,
  input wire pinOutputEnable,
  output wire rawResult,
  output wire resultPin,
  output wire resultPinOen
);

  // Selected non-inverting level
  reg [AW-1:0] plusLevel;
  // Selected inverting level
  reg [AW-1:0] minusLevel;

  ////////////////////////////////////////////////////////////////////////
  // Input multiplexers
  always @* begin
    // Reference or external pin on the plus side
    plusLevel = plusInputSelect ? referencePlus : analogInputA;
    case (minusInputSelect)
      `CMP_MINUS_B: minusLevel = analogInputB;
      `CMP_MINUS_C: minusLevel = analogInputC;
      `CMP_MINUS_D: minusLevel = analogInputD;
      default: minusLevel = referenceMinus;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Compare, polarity and off forcing; no clock anywhere on this path
  assign rawResult = comparatorOn & ((plusLevel > minusLevel) ^ outputInvert);
  // Pin carries the unsynchronised result
  assign resultPin = rawResult & pinOutputEnable;
  // Enable is low while the pin is driven
  assign resultPinOen = ~pinOutputEnable;

endmodule // comparator_channel

/* File: triple_comparator.v */
// Triple comparator control: registers, result sampling, events and interrupt
`include "triple_comparator_defs.vh"

module triple_comparator #(
  parameter AW = 10
) (
  // Clock, 100 MHz
  input wire mclk,
  // Synchronous reset, active low
  input wire rstn,
  // Clock enable, freezes all state while low
  input wire ce,
  // Register port
  input wire [7:0] addr,
  input wire [15:0] wdata,
  input wire wr,
  input wire rd,
  output wire [15:0] rdata,
  // Analog levels, one AW-wide slice per comparator
  input wire [3*AW-1:0] analogInputA,
  input wire [3*AW-1:0] analogInputB,
  input wire [3*AW-1:0] analogInputC,
  input wire [3*AW-1:0] analogInputD,
  // Shared reference levels
  input wire [AW-1:0] referencePlus,
  input wire [AW-1:0] referenceMinus,
  // Result pins with their enables
  output wire [2:0] resultPin,
  output wire [2:0] resultPinOen,
  // One-cycle trigger per comparator event
  output wire [2:0] eventTrigger,
  // Level interrupt
  output wire irq
);

  // Number of comparators
  localparam NUM_COMP = 3;

  ////////////////////////////////////////////////////////////////////////
  // Shared wires gathered from the channels

  // Control words as read back
  wire [16*NUM_COMP-1:0] ctrlRead;
  // Synchronised results
  wire [NUM_COMP-1:0] resultSync;
  // Event flags
  wire [NUM_COMP-1:0] eventFlags;
  // Accepted events this cycle
  wire [NUM_COMP-1:0] eventFire;
  // Trigger pulses
  wire [NUM_COMP-1:0] triggerPulse;

  ////////////////////////////////////////////////////////////////////////
  // Interrupt and read registers

  // Sticky interrupt status
  reg [NUM_COMP-1:0] intStatus_ff;
  // Interrupt mask, one enables
  reg [NUM_COMP-1:0] intMask_ff;
  // Read data register
  reg [15:0] readData_ff;
  // Next read data
  reg [15:0] nxt_readData;

  // Register selects
  wire statusSel = (addr == `CMP_STATUS_OFS);
  wire intStatusSel = (addr == `CMP_INT_STATUS_OFS);
  wire intMaskSel = (addr == `CMP_INT_MASK_OFS);

  ////////////////////////////////////////////////////////////////////////
  // Per-comparator logic
  genvar i;
  generate
    for (i = 0; i < NUM_COMP; i = i + 1) begin : chan
      // Byte offset of this control register
      localparam integer CH_OFS = `CMP_CTRL_STRIDE * i;

      // Comparator on
      reg compOn_ff;
      // Pin output enable
      reg pinOe_ff;
      // Output invert
      reg invert_ff;
      // Event edge select
      reg [1:0] edgeSel_ff;
      // Plus input select
      reg plusSel_ff;
      // Minus input select
      reg [1:0] minusSel_ff;
      // Sticky event flag
      reg eventFlag_ff;
      // First synchroniser stage, read only by the second
      reg syncA_ff;
      // Second synchroniser stage
      reg syncB_ff;
      // Previous synchronised result for edge detection
      reg prevResult_ff;
      // Trigger pulse register
      reg trigger_ff;

      // Raw, unclocked compare result
      wire rawResult;
      // Write to this control register
      wire ctrlWrite = wr & (addr == CH_OFS[7:0]);
      // Transitions of the synchronised result
      wire riseSeen = syncB_ff & ~prevResult_ff;
      wire fallSeen = ~syncB_ff & prevResult_ff;
      // Selected transition seen
      reg edgeHit;
      // Event accepted only while the flag is clear
      wire fire = edgeHit & compOn_ff & ~eventFlag_ff;

      // Analog selection and compare
      comparator_channel #(
        .AW(AW)
      ) u_channel (
        .analogInputA(analogInputA[i*AW +: AW]),
        .analogInputB(analogInputB[i*AW +: AW]),
        .analogInputC(analogInputC[i*AW +: AW]),
        .analogInputD(analogInputD[i*AW +: AW]),
        .referencePlus(referencePlus),
        .referenceMinus(referenceMinus),
        .comparatorOn(compOn_ff),
        .plusInputSelect(plusSel_ff),
        .minusInputSelect(minusSel_ff),
        .outputInvert(invert_ff),
        .pinOutputEnable(pinOe_ff),
        .rawResult(rawResult),
        .resultPin(resultPin[i]),
        .resultPinOen(resultPinOen[i])
      );

      // Edge selection on the polarity-adjusted result
      always @* begin
        case (edgeSel_ff)
          // Rising only
          `CMP_EDGE_RISE: edgeHit = riseSeen;
          // Falling only
          `CMP_EDGE_FALL: edgeHit = fallSeen;
          // Any change
          `CMP_EDGE_ANY: edgeHit = riseSeen | fallSeen;
          // Events disabled
          default: edgeHit = 1'b0;
        endcase
      end

      // Control fields written by software
      always @(posedge mclk) begin
        if (!rstn) begin
          // Everything off after reset
          compOn_ff <= 1'b0;
          pinOe_ff <= 1'b0;
          invert_ff <= 1'b0;
          edgeSel_ff <= 2'h0;
          plusSel_ff <= 1'b0;
          minusSel_ff <= 2'h0;
        end else if (ce && ctrlWrite) begin
          // Take the writable fields
          compOn_ff <= wdata[`CMP_ON_BIT];
          pinOe_ff <= wdata[`CMP_OE_BIT];
          invert_ff <= wdata[`CMP_INV_BIT];
          edgeSel_ff <= wdata[`CMP_EDGE_HI:`CMP_EDGE_LO];
          plusSel_ff <= wdata[`CMP_PLUS_BIT];
          minusSel_ff <= wdata[`CMP_MINUS_HI:`CMP_MINUS_LO];
        end
      end

      // Event flag: hardware set wins over software write
      always @(posedge mclk) begin
        if (!rstn) begin
          eventFlag_ff <= 1'b0;
        end else if (ce) begin
          if (fire) begin
            // New event sets the flag
            eventFlag_ff <= 1'b1;
          end else if (ctrlWrite) begin
            // Software clears or sets it
            eventFlag_ff <= wdata[`CMP_FLAG_BIT];
          end
        end
      end

      // Result synchroniser, edge history and trigger
      always @(posedge mclk) begin
        if (!rstn) begin
          syncA_ff <= 1'b0;
          syncB_ff <= 1'b0;
          prevResult_ff <= 1'b0;
          trigger_ff <= 1'b0;
        end else if (ce) begin
          // Two stages before edge detection and readback look at it
          syncA_ff <= rawResult;
          syncB_ff <= syncA_ff;
          prevResult_ff <= syncB_ff;
          // One pulse per accepted event
          trigger_ff <= fire;
        end
      end

      // Readback of this control register
      assign ctrlRead[i*16 +: 16] = {compOn_ff, pinOe_ff, invert_ff, 3'h0,
                                     eventFlag_ff, syncB_ff, edgeSel_ff, 1'b0,
                                     plusSel_ff, 2'h0, minusSel_ff};
      // Gathered state
      assign resultSync[i] = syncB_ff;
      assign eventFlags[i] = eventFlag_ff;
      assign eventFire[i] = fire;
      assign triggerPulse[i] = trigger_ff;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Interrupt status and mask

  // Status sets on events, a read clears, a set in the same cycle wins
  always @(posedge mclk) begin
    if (!rstn) begin
      intStatus_ff <= 3'h0;
    end else if (ce) begin
      if (rd && intStatusSel) begin
        // Clear on read, keep fresh events
        intStatus_ff <= eventFire;
      end else begin
        // Accumulate events
        intStatus_ff <= intStatus_ff | eventFire;
      end
    end
  end

  // Mask written by software
  always @(posedge mclk) begin
    if (!rstn) begin
      intMask_ff <= `CMP_INT_MASK_RESET;
    end else if (ce && wr && intMaskSel) begin
      intMask_ff <= wdata[NUM_COMP-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read path

  // Select the addressed register
  always @*  begin
    nxt_readData = 16'h0000;
    case (addr)
      // Per-comparator control words
      `CMP_CTRL0_OFS: nxt_readData = ctrlRead[15:0];
      `CMP_CTRL1_OFS: nxt_readData = ctrlRead[31:16];
      `CMP_CTRL2_OFS: nxt_readData = ctrlRead[47:32];
      // Results and flags of all comparators
      `CMP_STATUS_OFS: begin
        nxt_readData[`CMP_STAT_FLAG_LSB +: NUM_COMP] = eventFlags;
        nxt_readData[`CMP_STAT_RESULT_LSB +: NUM_COMP] = resultSync;
      end
      // Interrupt registers in the low bits
      `CMP_INT_STATUS_OFS: nxt_readData[NUM_COMP-1:0] = intStatus_ff;
      `CMP_INT_MASK_OFS: nxt_readData[NUM_COMP-1:0] = intMask_ff;
      // Unmapped reads as zero
      default: nxt_readData = 16'h0000;
    endcase
  end

  // Read data stand only in the cycle after the strobe
  always @(posedge mclk) begin
    if (!rstn) begin
      readData_ff <= 16'h0000;
    end else if (ce) begin
      if (rd) begin
        readData_ff <= nxt_readData;
      end else begin
        readData_ff <= 16'h0000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  assign rdata = readData_ff;
  assign eventTrigger = triggerPulse;
  // High while any unmasked status bit is set
  assign irq = |(intStatus_ff & intMask_ff);

endmodule // triple_comparator

/* File: triple_comparator_asserts.sv */
// Port assertions for the triple comparator block
module triple_comparator_asserts (
  input wire mclk,
  input wire rstn,
  input wire ce,
  input wire [7:0] addr,
  input wire wr,
  input wire rd,
  input wire [15:0] rdata,
  input wire [2:0] resultPin,
  input wire [2:0] resultPinOen,
  input wire [2:0] eventTrigger,
  input wire irq
);
  // One clock domain
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////
  property p_rdIdle; !$past(rd) |-> rdata == 16'h0000; endproperty
  a_rdIdle: assert property (p_rdIdle) else $error("read data not zero outside read");
  property p_rdUnmapped; rd && addr >= 8'h18 |=> rdata == 16'h0000; endproperty
  a_rdUnmapped: assert property (p_rdUnmapped) else $error("unmapped read not zero");
  property p_pinGated; (resultPin & resultPinOen) == 3'h0; endproperty
  a_pinGated: assert property (p_pinGated) else $error("pin driven while not enabled");
  property p_oenHold; !$past(wr) |-> $stable(resultPinOen); endproperty
  a_oenHold: assert property (p_oenHold) else $error("pin enable moved without write");
  property p_trigPulse; (eventTrigger & $past(eventTrigger)) == 3'h0; endproperty
  a_trigPulse: assert property (p_trigPulse) else $error("trigger longer than one cycle");
  property p_trigBlock; eventTrigger[0] && !wr ##1 !wr [*2] |=> !eventTrigger[0]; endproperty
  a_trigBlock: assert property (p_trigBlock) else $error("event repeated with flag set");
  property p_trigCe; eventTrigger != 3'h0 |-> $past(ce); endproperty
  a_trigCe: assert property (p_trigCe) else $error("trigger without clock enable");
  property p_irqRise; $rose(irq) |-> eventTrigger != 3'h0 || $past(wr); endproperty
  a_irqRise: assert property (p_irqRise) else $error("interrupt rose without cause");
  property p_irqFall; $fell(irq) |-> $past(wr) || ($past(rd) && $past(addr) == 8'h10); endproperty
  a_irqFall: assert property (p_irqFall) else $error("interrupt fell without cause");
  ////////////////////////////////////////
  c_trig: cover property (eventTrigger[0]);
  c_irqFall: cover property ($fell(irq));
  c_statRead: cover property (rd && addr == 8'h0c);
endmodule // triple_comparator_asserts

bind triple_comparator triple_comparator_asserts triple_comparator_asserts_inst (.mclk(mclk), .rstn(rstn),
  .ce(ce), .addr(addr), .wr(wr), .rd(rd), .rdata(rdata), .resultPin(resultPin), .resultPinOen(resultPinOen),
  .eventTrigger(eventTrigger), .irq(irq));

/* File: triple_comparator_tb.sv */
// Register-level testbench for the triple comparator block
module triple_comparator_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, ce = 1'b1, e;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic [29:0] inA = '0, inB = '0, inC = '0, inD = '0;
  logic [9:0] refP = '0, refM = '0;
  wire [15:0] rdata;
  wire [2:0] resultPin, resultPinOen, eventTrigger;
  wire irq;
  int num_errors = 0, samples_checked = 0, trigCount = 0, ch;
  // Input sets in order A, plus reference, B, C, D, minus reference
  logic [9:0] vals [4][6] = '{'{10'd300, 10'd550, 10'd100, 10'd500, 10'd200, 10'd400},
    '{10'd300, 10'd250, 10'd400, 10'd200, 10'd250, 10'd350},
    '{10'd100, 10'd0, 10'd200, 10'd0, 10'd0, 10'd0}, '{10'd300, 10'd0, 10'd200, 10'd0, 10'd0, 10'd0}};
  always #5 mclk = ~mclk;
  // Counts event pulses of the first comparator
  always @(posedge mclk) if (eventTrigger[0] === 1'b1) trigCount <= trigCount + 1;
  triple_comparator triple_comparator_inst (.mclk(mclk), .rstn(rstn), .ce(ce), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .analogInputA(inA), .analogInputB(inB), .analogInputC(inC),
    .analogInputD(inD), .referencePlus(refP), .referenceMinus(refM), .resultPin(resultPin),
    .resultPinOen(resultPinOen), .eventTrigger(eventTrigger), .irq(irq));
  ////////////////////////////////////////
  task automatic give_verdict;
    $display("Checks %0d, mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wrReg(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task automatic rdReg(input logic [7:0] a, input logic [15:0] exp);
    @(posedge mclk);
    rd <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask
  task automatic setIn(input int s);
    @(posedge mclk);
    inA <= {3{vals[s][0]}};
    refP <= vals[s][1];
    inB <= {3{vals[s][2]}};
    inC <= {3{vals[s][3]}};
    inD <= {3{vals[s][4]}};
    refM <= vals[s][5];
  endtask
  // Bounded wait for the event counter
  task automatic waitTrig(input int n);
    for (int i = 0; i < 20 && trigCount < n; i++) @(posedge mclk) #1;
    chk(16'(trigCount), 16'(n));
    if (trigCount < n) give_verdict();
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (8) @(posedge mclk);
    chk(16'(resultPinOen), 16'h0007);
    rstn <= 1'b1;
    foreach (vals[0][i]) rdReg(8'(4 * i), 16'h0000);
    // Input select sweep over all codes, all three comparators
    for (int s = 0; s < 2; s++) begin
      setIn(s);
      for (int k = 0; k < 8; k++) begin
        ch = k % 3;
        e = (vals[s][k / 4] > vals[s][2 + k % 4]) ^ s[0];
        wrReg(8'(4 * ch), 16'hc000 | 16'(s) << 13 | 16'(k / 4) << 4 | 16'(k % 4));
        #1;
        chk({15'h0, resultPin[ch]}, {15'h0, e});
        chk(16'(resultPinOen), 16'(3'h7 & ~(3'h1 << ch)));
        repeat (3) @(posedge mclk);
        rdReg(8'h0c, 16'(e) << ch);
        rdReg(8'(4 * ch), 16'hc000 | 16'(s) << 13 | 16'(k / 4) << 4 | 16'(k % 4) | 16'(e) << 8);
        wrReg(8'(4 * ch), 16'h0000);
      end
    end
    chk(16'(trigCount), 16'h0000);
    // Comparator off with pin enabled
    wrReg(8'h00, 16'h4002);
    repeat (3) @(posedge mclk);
    chk(16'(resultPin), 16'h0000);
    rdReg(8'h0c, 16'h0000);
    // Rising event, blocking flag and interrupt
    wrReg(8'h14, 16'h0007);
    rdReg(8'h14, 16'h0007);
    setIn(2);
    wrReg(8'h00, 16'h8040);
    setIn(3);
    waitTrig(1);
    chk({15'h0, irq}, 16'h0001);
    rdReg(8'h00, 16'h8340);
    rdReg(8'h0c, 16'h0101);
    setIn(2);
    setIn(3);
    repeat (6) @(posedge mclk);
    chk(16'(trigCount), 16'h0001);
    rdReg(8'h10, 16'h0001);
    chk({15'h0, irq}, 16'h0000);
    rdReg(8'h10, 16'h0000);
    // Clear flag, masked event
    wrReg(8'h14, 16'h0000);
    wrReg(8'h00, 16'h8040);
    setIn(2);
    setIn(3);
    waitTrig(2);
    chk({15'h0, irq}, 16'h0000);
    wrReg(8'h14, 16'h0001);
    #1;
    chk({15'h0, irq}, 16'h0001);
    rdReg(8'h10, 16'h0001);
    // Clock enable low: a write must be ignored
    @(posedge mclk);
    ce <= 1'b0;
    wrReg(8'h14, 16'h0000);
    ce <= 1'b1;
    rdReg(8'h14, 16'h0001);
    give_verdict();
  end
endmodule // triple_comparator_tb
